//--- design/hwcfg_pkg.sv
/*
  package for the hardware configuration memory: configuration addresses,
  field positions, fixed bits, reset values and enumerated settings.
  assumes nothing beyond a SystemVerilog compiler.
*/
package hwcfg_pkg;
    // configuration addresses of the three words
    localparam logic [7:0] ADDR_CLOCK_SOURCE_CONFIG = 8'h3d;
    localparam logic [7:0] ADDR_BROWNOUT_CONFIG = 8'h3e;
    localparam logic [7:0] ADDR_MEMORY_ACCESS_CONFIG = 8'h3f;
    // memory access word field positions
    localparam int POS_PROGRAM_ACCESS_SECURITY = 7;
    localparam int POS_PROGRAM_MEMORY_LOCK = 6;
    localparam int POS_RESET_SECTOR_LOCK = 5;
    localparam int POS_BOOT_ROM_ENABLE = 4;
    localparam int POS_WATCHDOG_RESET_ENABLE = 3;
    localparam int POS_DATA_FLASH_SIZE = 0;
    // brownout word field positions
    localparam int POS_BROWNOUT_LEVEL_SELECT = 4;
    localparam int POS_BROWNOUT_DISABLE = 2;
    // clock source word field position
    localparam int POS_CLOCK_SOURCE_SELECT = 0;
    // fixed bits forced on every store
    localparam logic [7:0] MEMORY_ACCESS_FIXED_ONES = 8'h04;
    localparam logic [7:0] BROWNOUT_FIXED_ONES = 8'h0b;
    localparam logic [7:0] CLOCK_SOURCE_WRITABLE = 8'h07;
    // erased (default) contents
    localparam logic [7:0] MEMORY_ACCESS_RESET = 8'hff;
    localparam logic [7:0] BROWNOUT_RESET = 8'hff;
    localparam logic [7:0] CLOCK_SOURCE_RESET = 8'h07;
    // data flash size codes
    localparam logic [1:0] DFLASH_4KB = 2'h0;
    localparam logic [1:0] DFLASH_NONE = 2'h3;
    // highest legal brownout level code
    localparam logic [3:0] BROWNOUT_LEVEL_MAX = 4'h8;
    // clock source codes
    typedef enum logic [2:0] {
        CLK_RESERVED0 = 3'h0,
        CLK_RESERVED1 = 3'h1,
        CLK_RESERVED2 = 3'h2,
        CLK_EXTERNAL = 3'h3,
        CLK_PLL_HF = 3'h4,
        CLK_PLL_LF = 3'h5,
        CLK_OSC_HF = 3'h6,
        CLK_OSC_LF = 3'h7
    } clock_source_t;
endpackage

//--- design/hwcfg_decode.sv
/*
  combinational decoder from the latched configuration words to control
  values. assumes the words are stable between resets.
*/
`timescale 1ns/1ps
module hwcfg_decode (
    // latched words
    input wire logic [7:0] mem_word,
    input wire logic [7:0] bo_word,
    input wire logic [7:0] clk_word,
    // device context
    input wire logic serial_program_mode,
    input wire logic large_flash,
    // decoded controls
    output logic pm_write_allow,
    output logic rs_write_allow,
    output logic [1:0] data_flash_size,
    output logic bo_detect_enable,
    output logic bo_level_valid,
    output hwcfg_pkg::clock_source_t clock_source
);
    logic program_memory_lock;
    logic reset_sector_lock;
    logic [1:0] dfs;
    logic [2:0] cs;

    // field decode and mode overrides
    always_comb
    begin
        program_memory_lock = mem_word[hwcfg_pkg::POS_PROGRAM_MEMORY_LOCK];
        reset_sector_lock = mem_word[hwcfg_pkg::POS_RESET_SECTOR_LOCK];
        pm_write_allow = ~program_memory_lock; // [RULE_04]
        // program lock decides; small part treats reset sector as whole memory
        if (program_memory_lock || !large_flash) // [RULE_05] [RULE_07]
        begin
            rs_write_allow = ~program_memory_lock & ~reset_sector_lock;
            if (!large_flash)
            begin
                pm_write_allow = ~program_memory_lock & ~reset_sector_lock;
            end
        end
        else
        begin
            rs_write_allow = ~reset_sector_lock; // [RULE_06]
        end
        dfs = mem_word[hwcfg_pkg::POS_DATA_FLASH_SIZE +: 2];
        // 4kB only exists on the large part
        if (dfs == hwcfg_pkg::DFLASH_4KB && !large_flash) // [RULE_10]
        begin
            data_flash_size = hwcfg_pkg::DFLASH_NONE;
        end
        else
        begin
            data_flash_size = dfs;
        end
        bo_level_valid = bo_word[hwcfg_pkg::POS_BROWNOUT_LEVEL_SELECT +: 4]
            <= hwcfg_pkg::BROWNOUT_LEVEL_MAX; // [RULE_11]
        bo_detect_enable = ~bo_word[hwcfg_pkg::POS_BROWNOUT_DISABLE]
            & ~serial_program_mode; // [RULE_12] [RULE_17]
        cs = clk_word[hwcfg_pkg::POS_CLOCK_SOURCE_SELECT +: 3];
        if (serial_program_mode) // [RULE_16]
        begin
            clock_source = hwcfg_pkg::CLK_OSC_LF;
        end
        else
        begin
            clock_source = hwcfg_pkg::clock_source_t'(cs); // [RULE_13]
        end
    end
endmodule

//--- design/hardware_config_memory.sv
/*
  hardware configuration memory: three non-volatile configuration words
  reached by configuration address, written only in serial programming
  mode, read back in user mode, decoded into device controls at reset.
  assumes synchronous inputs on CLOCK and that the nonvolatile array
  contents are modelled by the held words (erased value after power-on).
*/
// What this block does
// RULE_01: writes accepted only in serial programming mode
// RULE_02: user mode reads words by configuration address
// RULE_03: security bit zero blocks programming-mode flash access
// RULE_04: program lock one makes program memory read-only
// RULE_05: program lock overrides reset sector lock
// RULE_06: reset sector lock one protects 4kB sector
// RULE_07: small part: sector lock equals program lock
// RULE_08: boot rom enable maps 1kB boot rom
// RULE_09: watchdog reset enable gates watchdog reset
// RULE_10: two-bit field selects data flash size
// RULE_11: four-bit brownout level, codes above eight reserved
// RULE_12: brownout disable bit turns detection off
// RULE_13: three-bit field selects system clock source
// RULE_14: clock status readable in pll status register
// RULE_15: host holds request pin low through reset
// RULE_16: programming mode forces oscillator low-frequency clock
// RULE_17: programming mode keeps brownout detection off
// RULE_18: settings load at reset, held until next
`timescale 1ns/1ps
module hardware_config_memory (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // device context
    input wire logic PROGRAM_REQUEST_PIN,
    input wire logic LARGE_FLASH,
    input wire logic MASS_ERASE,
    input wire logic WATCHDOG_TIMEOUT,
    // configuration access port
    input wire logic [7:0] CONFIG_ADDRESS_POINTER,
    input wire logic CFG_WRITE,
    input wire logic [7:0] CFG_WDATA,
    input wire logic CFG_READ,
    output logic [7:0] CFG_RDATA,
    output logic CFG_RVALID,
    // status
    output logic SERIAL_PROGRAM_MODE,
    output logic [7:0] PLL_STATUS_HIGH,
    // decoded controls
    output logic PROGRAM_ACCESS_SECURITY,
    output logic PROGRAM_MEMORY_WRITE_ALLOW,
    output logic RESET_SECTOR_WRITE_ALLOW,
    output logic BOOT_ROM_ENABLE,
    output logic WATCHDOG_RESET,
    output logic [1:0] DATA_FLASH_SIZE,
    output logic [3:0] BROWNOUT_LEVEL_SELECT,
    output logic BROWNOUT_LEVEL_VALID,
    output logic BROWNOUT_DETECT_ENABLE,
    output logic [2:0] CLOCK_SOURCE_SELECT
);
    // nonvolatile words, indexed 0 clock, 1 brownout, 2 memory access
    logic [7:0] nv_r [3];
    logic [7:0] nv_nxt [3];
    logic powered_r;
    logic powered_nxt;
    // shadow copies taken at reset release
    logic [7:0] mem_r;
    logic [7:0] mem_nxt;
    logic [7:0] bo_r;
    logic [7:0] bo_nxt;
    logic [7:0] clk_r;
    logic [7:0] clk_nxt;
    logic spm_r;
    logic spm_nxt;
    logic loaded_r;
    logic loaded_nxt;
    logic locked_r;
    logic locked_nxt;
    // read port
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    // decoder results
    logic pm_wa;
    logic rs_wa;
    logic [1:0] dfs;
    logic bo_en;
    logic bo_valid;
    hwcfg_pkg::clock_source_t cs;
    // registered outputs
    logic wdr_r;
    logic wdr_nxt;
    logic [7:0] pll_status_high_r;
    logic [7:0] pll_status_high_nxt;
    // decoded control word, bit 0 is the programming mode flag
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;

    // index of a configuration address, 3 when unmapped
    function automatic logic [1:0] word_index(input logic [7:0] addr);
        case (addr)
            hwcfg_pkg::ADDR_CLOCK_SOURCE_CONFIG: word_index = 2'h0;
            hwcfg_pkg::ADDR_BROWNOUT_CONFIG: word_index = 2'h1;
            hwcfg_pkg::ADDR_MEMORY_ACCESS_CONFIG: word_index = 2'h2;
            default: word_index = 2'h3;
        endcase
    endfunction

    // fixed bits forced onto a word
    function automatic logic [7:0] fix_word(input logic [1:0] idx, input logic [7:0] d);
        case (idx)
            2'h0: fix_word = d & hwcfg_pkg::CLOCK_SOURCE_WRITABLE;
            2'h1: fix_word = d | hwcfg_pkg::BROWNOUT_FIXED_ONES;
            2'h2: fix_word = d | hwcfg_pkg::MEMORY_ACCESS_FIXED_ONES;
            default: fix_word = 8'h00;
        endcase
    endfunction

    hwcfg_decode u_decode (
        .mem_word(mem_r),
        .bo_word(bo_r),
        .clk_word(clk_r),
        .serial_program_mode(spm_r),
        .large_flash(LARGE_FLASH),
        .pm_write_allow(pm_wa),
        .rs_write_allow(rs_wa),
        .data_flash_size(dfs),
        .bo_detect_enable(bo_en),
        .bo_level_valid(bo_valid),
        .clock_source(cs)
    );

    // nonvolatile store and shadow load
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            nv_nxt[i] = nv_r[i];
        end
        powered_nxt = 1'b1;
        mem_nxt = mem_r;
        bo_nxt = bo_r;
        clk_nxt = clk_r;
        spm_nxt = spm_r;
        loaded_nxt = 1'b1;
        locked_nxt = locked_r;
        // a power-on flag that is not yet set fills the erased words
        if (powered_r)
        begin
            if (!loaded_r)
            begin
                // capture words and mode once after reset release
                mem_nxt = nv_r[2]; // [RULE_18]
                bo_nxt = nv_r[1];
                clk_nxt = nv_r[0];
                spm_nxt = ~PROGRAM_REQUEST_PIN; // [RULE_15]
                locked_nxt = ~PROGRAM_REQUEST_PIN
                    & ~nv_r[2][hwcfg_pkg::POS_PROGRAM_ACCESS_SECURITY]; // [RULE_03]
            end
            else if (spm_r && MASS_ERASE)
            begin
                locked_nxt = 1'b0;
                nv_nxt[0] = hwcfg_pkg::CLOCK_SOURCE_RESET;
                nv_nxt[1] = hwcfg_pkg::BROWNOUT_RESET;
                nv_nxt[2] = hwcfg_pkg::MEMORY_ACCESS_RESET;
            end
            // writes only land in programming mode; shadows stay put
            else if (CFG_WRITE && spm_r && !locked_r
                && word_index(CONFIG_ADDRESS_POINTER) != 2'h3) // [RULE_01]
            begin
                nv_nxt[word_index(CONFIG_ADDRESS_POINTER)] =
                    fix_word(word_index(CONFIG_ADDRESS_POINTER), CFG_WDATA);
            end
        end
        else
        begin
            nv_nxt[0] = hwcfg_pkg::CLOCK_SOURCE_RESET;
            nv_nxt[1] = hwcfg_pkg::BROWNOUT_RESET;
            nv_nxt[2] = hwcfg_pkg::MEMORY_ACCESS_RESET;
        end
    end

    // read port, pll status and watchdog reset
    always_comb
    begin
        rvalid_nxt = CFG_READ & loaded_r;
        rdata_nxt = rdata_r;
        if (CFG_READ && loaded_r)
        begin
            if (word_index(CONFIG_ADDRESS_POINTER) == 2'h3 || (spm_r && locked_r))
            begin
                rdata_nxt = 8'h00;
            end
            else
            begin
                rdata_nxt = nv_r[word_index(CONFIG_ADDRESS_POINTER)]; // [RULE_02]
            end
        end
        pll_status_high_nxt = {5'h00, cs}; // [RULE_14]
        wdr_nxt = WATCHDOG_TIMEOUT & mem_r[hwcfg_pkg::POS_WATCHDOG_RESET_ENABLE]; // [RULE_09]
        ctl_nxt = {mem_r[hwcfg_pkg::POS_PROGRAM_ACCESS_SECURITY] & ~locked_r, pm_wa, rs_wa,
            mem_r[hwcfg_pkg::POS_BOOT_ROM_ENABLE], dfs, // [RULE_08]
            bo_r[hwcfg_pkg::POS_BROWNOUT_LEVEL_SELECT +: 4], bo_valid, bo_en,
            3'(cs), spm_r};
    end

    // nonvolatile array survives RST_N, only power-on or mass erase fills it
    always_ff @(posedge CLOCK)
    begin
        powered_r <= powered_nxt;
        for (int i = 0; i < 3; i++)
        begin
            nv_r[i] <= nv_nxt[i];
        end
    end

    // reset-scoped state
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            mem_r <= hwcfg_pkg::MEMORY_ACCESS_RESET;
            bo_r <= hwcfg_pkg::BROWNOUT_RESET;
            clk_r <= hwcfg_pkg::CLOCK_SOURCE_RESET;
            spm_r <= 1'b0;
            loaded_r <= 1'b0;
            locked_r <= 1'b0;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            pll_status_high_r <= 8'h00;
            wdr_r <= 1'b0;
            ctl_r <= 16'h0000;
        end
        else
        begin
            mem_r <= mem_nxt;
            bo_r <= bo_nxt;
            clk_r <= clk_nxt;
            spm_r <= spm_nxt;
            loaded_r <= loaded_nxt;
            locked_r <= locked_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            pll_status_high_r <= pll_status_high_nxt;
            wdr_r <= wdr_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    // decoded control outputs straight from the control register
    assign PROGRAM_ACCESS_SECURITY = ctl_r[15];
    assign PROGRAM_MEMORY_WRITE_ALLOW = ctl_r[14];
    assign RESET_SECTOR_WRITE_ALLOW = ctl_r[13];
    assign BOOT_ROM_ENABLE = ctl_r[12];
    assign DATA_FLASH_SIZE = ctl_r[11:10];
    assign BROWNOUT_LEVEL_SELECT = ctl_r[9:6];
    assign BROWNOUT_LEVEL_VALID = ctl_r[5];
    assign BROWNOUT_DETECT_ENABLE = ctl_r[4];
    assign CLOCK_SOURCE_SELECT = ctl_r[3:1];
    assign SERIAL_PROGRAM_MODE = ctl_r[0];
    assign CFG_RDATA = rdata_r;
    assign CFG_RVALID = rvalid_r;
    assign PLL_STATUS_HIGH = pll_status_high_r;
    assign WATCHDOG_RESET = wdr_r;
endmodule

//--- bench/hwcfg_asserts.sv
/*
  concurrent checks on the configuration memory ports.
  assumes binding to hardware_config_memory, one clock domain.
*/
`timescale 1ns/1ps
module hwcfg_asserts (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // inputs watched
    input wire logic LARGE_FLASH,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic CFG_READ,
    // outputs watched
    input wire logic CFG_RVALID,
    input wire logic SERIAL_PROGRAM_MODE,
    input wire logic [7:0] PLL_STATUS_HIGH,
    input wire logic PROGRAM_MEMORY_WRITE_ALLOW,
    input wire logic RESET_SECTOR_WRITE_ALLOW,
    input wire logic WATCHDOG_RESET,
    input wire logic [1:0] DATA_FLASH_SIZE,
    input wire logic [3:0] BROWNOUT_LEVEL_SELECT,
    input wire logic BROWNOUT_LEVEL_VALID,
    input wire logic BROWNOUT_DETECT_ENABLE,
    input wire logic [2:0] CLOCK_SOURCE_SELECT
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    // decoded outputs settle within four edges of release
    sequence s_settled;
        RST_N [*4];
    endsequence
    sequence s_program_request_pin;
        SERIAL_PROGRAM_MODE [*4];
    endsequence
    // read answered exactly one cycle later
    property p_read; CFG_READ && $past(RST_N) |=> CFG_RVALID; endproperty
    a_read: assert property (p_read) else $error("read not answered");
    property p_wdog; WATCHDOG_RESET |-> $past(WATCHDOG_TIMEOUT); endproperty
    a_wdog: assert property (p_wdog) else $error("stray watchdog reset");
    property p_pclk; s_program_request_pin |-> PLL_STATUS_HIGH == 8'h07; endproperty
    a_pclk: assert property (p_pclk) else $error("programming clock wrong");
    property p_pbo; s_program_request_pin |-> !BROWNOUT_DETECT_ENABLE; endproperty
    a_pbo: assert property (p_pbo) else $error("brownout on in programming");
    property p_hold;
        s_settled |=> $stable({DATA_FLASH_SIZE, BROWNOUT_LEVEL_SELECT, CLOCK_SOURCE_SELECT});
    endproperty
    a_hold: assert property (p_hold) else $error("decoded setting moved");
    property p_lvl; s_settled |-> BROWNOUT_LEVEL_VALID == (BROWNOUT_LEVEL_SELECT <= 4'h8); endproperty
    a_lvl: assert property (p_lvl) else $error("level validity wrong");
    property p_pml; s_settled ##0 !PROGRAM_MEMORY_WRITE_ALLOW |-> !RESET_SECTOR_WRITE_ALLOW; endproperty
    a_pml: assert property (p_pml) else $error("sector open under lock");
    property p_small;
        s_settled ##0 !LARGE_FLASH |-> RESET_SECTOR_WRITE_ALLOW == PROGRAM_MEMORY_WRITE_ALLOW;
    endproperty
    a_small: assert property (p_small) else $error("small part locks differ");
    property p_pll;
        s_settled ##0 !SERIAL_PROGRAM_MODE |-> PLL_STATUS_HIGH == {5'h00, CLOCK_SOURCE_SELECT};
    endproperty
    a_pll: assert property (p_pll) else $error("clock status mismatch");
endmodule

//--- bench/hwcfg_host.sv
/*
  programming host model: request pin and single-byte config cycles.
  assumes the block samples on the rising clock edge.
*/
`timescale 1ns/1ps
module hwcfg_host (
    // clock
    input wire logic clock,
    // answer from the block
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // request pin and access port
    output logic program_request_pin,
    output logic [7:0] addr,
    output logic wr,
    output logic [7:0] wdata,
    output logic rd
);
    // idle levels at time zero
    initial
    begin
        program_request_pin = 1'h1;
        addr = 8'h00;
        wr = 1'h0;
        wdata = 8'h00;
        rd = 1'h0;
    end
    // low across reset asks for programming mode
    task hold_pin(input logic v);
        program_request_pin = v;
    endtask
    // one write, bus scrambled once released
    task write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        wr = 1'h1;
        @(negedge clock);
        wr = 1'h0;
        addr = ~a;
        wdata = ~d;
    endtask
    // one read, answer taken the cycle after
    task read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clock);
        addr = a;
        rd = 1'h1;
        @(negedge clock);
        rd = 1'h0;
        addr = ~a;
        d = rdata;
        v = rvalid;
    endtask
endmodule

//--- bench/hardware_config_memory_tb.sv
/*
  self-checking bench for the configuration memory.
  assumes hwcfg_host and hwcfg_asserts are compiled first.
*/
`timescale 1ns/1ps
module hardware_config_memory_tb;
    logic CLOCK, RST_N, PROGRAM_REQUEST_PIN, LARGE_FLASH, MASS_ERASE, WATCHDOG_TIMEOUT;
    logic CFG_WRITE, CFG_READ, CFG_RVALID, SERIAL_PROGRAM_MODE, PROGRAM_ACCESS_SECURITY;
    logic PROGRAM_MEMORY_WRITE_ALLOW, RESET_SECTOR_WRITE_ALLOW, BOOT_ROM_ENABLE;
    logic WATCHDOG_RESET, BROWNOUT_LEVEL_VALID, BROWNOUT_DETECT_ENABLE;
    logic [7:0] CONFIG_ADDRESS_POINTER, CFG_WDATA, CFG_RDATA, PLL_STATUS_HIGH;
    logic [1:0] DATA_FLASH_SIZE;
    logic [3:0] BROWNOUT_LEVEL_SELECT;
    logic [2:0] CLOCK_SOURCE_SELECT;
    logic [15:0] dec;
    int fail_count, comparisons;
    // decoded controls packed for one compare
    assign dec = {1'h0, PROGRAM_ACCESS_SECURITY, PROGRAM_MEMORY_WRITE_ALLOW,
        RESET_SECTOR_WRITE_ALLOW, BOOT_ROM_ENABLE, DATA_FLASH_SIZE, BROWNOUT_LEVEL_SELECT,
        BROWNOUT_LEVEL_VALID, BROWNOUT_DETECT_ENABLE, CLOCK_SOURCE_SELECT};
    hardware_config_memory u_dut (.CLOCK, .RST_N, .PROGRAM_REQUEST_PIN, .LARGE_FLASH,
        .MASS_ERASE, .WATCHDOG_TIMEOUT, .CONFIG_ADDRESS_POINTER, .CFG_WRITE, .CFG_WDATA,
        .CFG_READ, .CFG_RDATA, .CFG_RVALID, .SERIAL_PROGRAM_MODE, .PLL_STATUS_HIGH,
        .PROGRAM_ACCESS_SECURITY, .PROGRAM_MEMORY_WRITE_ALLOW, .RESET_SECTOR_WRITE_ALLOW,
        .BOOT_ROM_ENABLE, .WATCHDOG_RESET, .DATA_FLASH_SIZE, .BROWNOUT_LEVEL_SELECT,
        .BROWNOUT_LEVEL_VALID, .BROWNOUT_DETECT_ENABLE, .CLOCK_SOURCE_SELECT);
    hwcfg_host u_host (.clock(CLOCK), .rdata(CFG_RDATA), .rvalid(CFG_RVALID),
        .program_request_pin(PROGRAM_REQUEST_PIN), .addr(CONFIG_ADDRESS_POINTER),
        .wr(CFG_WRITE), .wdata(CFG_WDATA), .rd(CFG_READ));
    // 100 MHz clock
    initial
    begin
        CLOCK = 1'h0;
        forever #5 CLOCK = ~CLOCK;
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task test_done;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset for two cycles, pin held until the sample edge has passed
    task rst(input logic pin);
        @(negedge CLOCK);
        RST_N = 1'h0;
        u_host.hold_pin(pin);
        repeat (2) @(negedge CLOCK);
        RST_N = 1'h1;
        repeat (4) @(negedge CLOCK);
        u_host.hold_pin(1'h1);
        chk({15'h0, SERIAL_PROGRAM_MODE}, {15'h0, ~pin});
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        u_host.read_byte(a, d, v);
        chk({15'h0, v}, 16'h0001);
        chk({8'h0, d}, {8'h0, e});
    endtask
    task wdog(input logic e);
        @(negedge CLOCK);
        WATCHDOG_TIMEOUT = 1'h1;
        @(negedge CLOCK);
        WATCHDOG_TIMEOUT = 1'h0;
        chk({15'h0, WATCHDOG_RESET}, {15'h0, e});
    endtask
    // erased words, user-mode write refused, unmapped read
    task t_erased;
        rst(1'h1);
        rchk(8'h3f, 8'hff);
        rchk(8'h3e, 8'hff);
        rchk(8'h3d, 8'h07);
        rchk(8'h40, 8'h00);
        u_host.write_byte(8'h3f, 8'h00);
        rchk(8'h3f, 8'hff);
        chk(dec, 16'h4fe7);
        chk({8'h0, PLL_STATUS_HIGH}, 16'h0007);
        wdog(1'h1);
    endtask
    // programming mode stores words with fixed bits, controls untouched
    task t_program;
        rst(1'h0);
        u_host.write_byte(8'h3f, 8'h82);
        rchk(8'h3f, 8'h86);
        u_host.write_byte(8'h3e, 8'h40);
        rchk(8'h3e, 8'h4b);
        u_host.write_byte(8'h3d, 8'hfc);
        rchk(8'h3d, 8'h04);
        chk(dec, 16'h4fe7);
    endtask
    // new words take effect from the next user-mode reset
    task t_apply;
        rst(1'h1);
        chk(dec, 16'h749c);
        chk({8'h0, PLL_STATUS_HIGH}, 16'h0004);
        wdog(1'h0);
    endtask
    // small part, security lock, mass erase, reserved level
    task t_lock;
        rst(1'h0);
        u_host.write_byte(8'h3f, 8'h20);
        LARGE_FLASH = 1'h0;
        rst(1'h1);
        chk(dec, 16'h069c);
        rst(1'h0);
        rchk(8'h3f, 8'h00);
        chk({7'h0, BROWNOUT_DETECT_ENABLE, PLL_STATUS_HIGH}, 16'h0007);
        @(negedge CLOCK);
        MASS_ERASE = 1'h1;
        @(negedge CLOCK);
        MASS_ERASE = 1'h0;
        rchk(8'h3f, 8'hff);
        u_host.write_byte(8'h3e, 8'h90);
        rst(1'h1);
        chk({11'h0, BROWNOUT_LEVEL_SELECT, BROWNOUT_LEVEL_VALID}, 16'h0012);
    endtask
    // large part 4kB data flash, oscillator high-frequency clock
    task t_codes;
        LARGE_FLASH = 1'h1;
        rst(1'h0);
        u_host.write_byte(8'h3f, 8'hfc);
        u_host.write_byte(8'h3d, 8'h06);
        rst(1'h1);
        chk({13'h0, DATA_FLASH_SIZE, PROGRAM_MEMORY_WRITE_ALLOW}, 16'h0000);
        chk({5'h0, CLOCK_SOURCE_SELECT, PLL_STATUS_HIGH}, 16'h0606);
    endtask
    // main sequence
    initial
    begin
        RST_N = 1'h0;
        LARGE_FLASH = 1'h1;
        MASS_ERASE = 1'h0;
        WATCHDOG_TIMEOUT = 1'h0;
        t_erased;
        t_program;
        t_apply;
        t_lock;
        t_codes;
        test_done;
    end
    // hang guard, far beyond the hundred or so cycles needed
    initial
    begin
        #100000;
        fail_count++;
        test_done;
    end
endmodule
bind hardware_config_memory hwcfg_asserts u_chk (.CLOCK, .RST_N, .LARGE_FLASH,
    .WATCHDOG_TIMEOUT, .CFG_READ, .CFG_RVALID, .SERIAL_PROGRAM_MODE, .PLL_STATUS_HIGH,
    .PROGRAM_MEMORY_WRITE_ALLOW, .RESET_SECTOR_WRITE_ALLOW, .WATCHDOG_RESET,
    .DATA_FLASH_SIZE, .BROWNOUT_LEVEL_SELECT, .BROWNOUT_LEVEL_VALID,
    .BROWNOUT_DETECT_ENABLE, .CLOCK_SOURCE_SELECT);
